// file: common/trd_defines.vh
`ifndef TRD_DEFINES_VH
`define TRD_DEFINES_VH
`define TRD_CLK_HZ        200000000
`define TRD_PWM_HZ        9000
`define TRD_PWM_PERIOD    (`TRD_CLK_HZ / `TRD_PWM_HZ)
`define TRD_TEMP_W        8
// Temperature code is degrees C offset by 20 (code = T - 20), saturating
`define TRD_CODE_25C      8'h05
// Duty per mille: 1000/162.3 per degree, offset from 20.1 C
`define TRD_DUTY_MIN_PM   10
`define TRD_DUTY_SLOPE_NUM 6161
`define TRD_DUTY_SLOPE_DEN 1000
`define TRD_DUTY_BIAS     100
`define TRD_PM_FULL       1000
`define TRD_BLANK_CYC     200
`define TRD_SYNC_W        5
`endif

// file: src/trd_sync.v
`timescale 1ns/1ps
module trd_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst_b,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  // Three stages; output changes once stages two and three agree
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1)
        if (s2_r[i] == s3_r[i])
          dout[i] <= s3_r[i];
    end
  end
endmodule

// file: src/trd_top.v
`timescale 1ns/1ps
`include "trd_defines.vh"
module trd_top #(
  parameter BLANK_CYC  = `TRD_BLANK_CYC,
  parameter PWM_PERIOD = `TRD_PWM_PERIOD
) (
  input  wire                   sys_clk,
  input  wire                   rst_b,
  input  wire                   gate_cmd,
  input  wire                   supply_above_rise,
  input  wire                   supply_above_fall,
  input  wire                   aux_five_volt_rail_ok,
  input  wire                   negative_bias_rail_ok,
  input  wire                   switch_overheat,
  input  wire                   driver_overheat,
  input  wire                   drain_negative,
  input  wire                   drain_forward,
  input  wire [`TRD_TEMP_W-1:0] temp_code,
  output reg                    switch_on_r,
  output reg                    rails_enable_r,
  output reg                    fault_b_r,
  output reg                    temp_pwm_r,
  output reg  [2:0]             diode_emulation_state_r
);
  localparam [2:0] ST_BLANK = 3'b001;
  localparam [2:0] ST_OFF   = 3'b010;
  localparam [2:0] ST_ON    = 3'b100;
  localparam [31:0] PM_TICK = PWM_PERIOD / `TRD_PM_FULL;

  wire [`TRD_SYNC_W-1:0] sy;
  wire [`TRD_TEMP_W-1:0] temp_s;
  // Asynchronous pins into the clock domain
  trd_sync #(.W(`TRD_SYNC_W)) u_sync_flags (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     ({gate_cmd, switch_overheat, driver_overheat, drain_negative, drain_forward}),
    .dout    (sy)
  );
  trd_sync #(.W(`TRD_TEMP_W)) u_sync_temp (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     (temp_code),
    .dout    (temp_s)
  );
  wire gate_s = sy[4];
  wire sw_hot = sy[3];
  wire drv_hot = sy[2];
  wire neg_s  = sy[1];
  wire fwd_s  = sy[0];

  wire [2:0] sup_s;
  trd_sync #(.W(3)) u_sync_sup (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     ({supply_above_rise, supply_above_fall,
               aux_five_volt_rail_ok & negative_bias_rail_ok}),
    .dout    (sup_s)
  );

  // Supply lockout: rails run after rise, stop below fall
  reg lockout_ok_r;
  reg ready_r;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lockout_ok_r <= 1'b0;
      ready_r      <= 1'b0;
    end
    else
    begin
      if (sup_s[2])
        lockout_ok_r <= 1'b1;
      else if (!sup_s[1])
        lockout_ok_r <= 1'b0;
      ready_r <= lockout_ok_r & sup_s[0];
    end
  end

  wire overheat_any = sw_hot | drv_hot;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rails_enable_r <= 1'b0;
      fault_b_r      <= 1'b0;
    end
    else
    begin
      rails_enable_r <= lockout_ok_r & ~drv_hot;
      fault_b_r      <= ready_r & ~overheat_any;
    end
  end

  // Overheat diode emulation
  reg        gate_d_r;
  reg        sw_hot_d_r;
  reg [15:0] blank_cnt_r;
  reg [2:0]  state_nxt;
  reg [15:0] blank_nxt;
  wire gate_fall = gate_d_r & ~gate_s;
  wire emul_act  = sw_hot & ~drv_hot & ready_r;
  always @*
  begin
    state_nxt = diode_emulation_state_r;
    blank_nxt = blank_cnt_r;
    if (!emul_act || !sw_hot_d_r)
    begin
      state_nxt = ST_OFF;
      blank_nxt = 16'h0000;
    end
    else if (gate_fall)
    begin
      state_nxt = ST_BLANK;
      blank_nxt = 16'h0000;
    end
    else
    begin
      case (diode_emulation_state_r)
        ST_BLANK:
        begin
          if (blank_cnt_r >= BLANK_CYC[15:0] - 16'h0001)
            state_nxt = ST_OFF;
          else
            blank_nxt = blank_cnt_r + 16'h0001;
        end
        ST_OFF:
          if (neg_s)
            state_nxt = ST_ON;
        ST_ON:
          if (fwd_s)
            state_nxt = ST_OFF;
        default:
          state_nxt = ST_OFF;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gate_d_r                <= 1'b0;
      sw_hot_d_r              <= 1'b0;
      blank_cnt_r             <= 16'h0000;
      diode_emulation_state_r <= ST_OFF;
    end
    else
    begin
      gate_d_r                <= gate_s;
      sw_hot_d_r              <= emul_act;
      blank_cnt_r             <= blank_nxt;
      diode_emulation_state_r <= state_nxt;
    end
  end

  // Switch drive
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      switch_on_r <= 1'b0;
    else if (!ready_r || drv_hot)
      switch_on_r <= 1'b0;
    else if (emul_act)
      switch_on_r <= (state_nxt == ST_ON);
    else
      switch_on_r <= gate_s;
  end

  // Take the code only when two samples agree; bits may settle a cycle apart
  reg [`TRD_TEMP_W-1:0] temp_d_r;
  reg [`TRD_TEMP_W-1:0] temp_q_r;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      temp_d_r <= {`TRD_TEMP_W{1'b0}};
      temp_q_r <= {`TRD_TEMP_W{1'b0}};
    end
    else
    begin
      temp_d_r <= temp_s;
      if (temp_s == temp_d_r)
        temp_q_r <= temp_s;
    end
  end

  // Temperature PWM: per mille duty, latched once per period
  reg [31:0] tick_r;
  reg [9:0]  pm_cnt_r;
  reg [9:0]  duty_r;
  reg [23:0] lin;
  reg [9:0]  duty_nxt;
  always @*
  begin
    lin = 24'h000000;
    lin = ({16'h0000, temp_q_r} * 24'd`TRD_DUTY_SLOPE_NUM + 24'd`TRD_DUTY_BIAS)
          / 24'd`TRD_DUTY_SLOPE_DEN;
    if (temp_q_r < `TRD_CODE_25C)
      duty_nxt = 10'd`TRD_DUTY_MIN_PM;
    else if (lin > 24'd`TRD_PM_FULL)
      duty_nxt = 10'd`TRD_PM_FULL;
    else
      duty_nxt = lin[9:0];
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_r     <= 32'h00000000;
      pm_cnt_r   <= 10'h000;
      duty_r     <= 10'h000;
      temp_pwm_r <= 1'b0;
    end
    else
    begin
      if (tick_r >= PM_TICK - 32'h00000001)
      begin
        tick_r <= 32'h00000000;
        if (pm_cnt_r == 10'd`TRD_PM_FULL - 10'h001)
        begin
          pm_cnt_r <= 10'h000;
          duty_r   <= duty_nxt;
        end
        else
          pm_cnt_r <= pm_cnt_r + 10'h001;
      end
      else
        tick_r <= tick_r + 32'h00000001;
      if (sw_hot | drv_hot)
        temp_pwm_r <= 1'b1;
      else
        temp_pwm_r <= (pm_cnt_r < duty_r);
    end
  end
endmodule

// file: tb/trd_chk.sv
`timescale 1ns/1ps
module trd_chk #(
  parameter BLANK_CYC = 4
) (
  input wire       sys_clk,
  input wire       rst_b,
  input wire       switch_overheat,
  input wire       driver_overheat,
  input wire       drain_negative,
  input wire       drain_forward,
  input wire       aux_five_volt_rail_ok,
  input wire       switch_on_r,
  input wire       rails_enable_r,
  input wire       fault_b_r,
  input wire       temp_pwm_r,
  input wire [2:0] diode_emulation_state_r
);
  wire [2:0] st;
  wire       emu;
  assign st = diode_emulation_state_r;
  assign emu = switch_overheat && !driver_overheat;
  reg [15:0] blank_run_r;
  // Cycles spent in the blank state
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      blank_run_r <= 16'h0000;
    else if (st == 3'h1)
      blank_run_r <= blank_run_r + 16'h0001;
    else
      blank_run_r <= 16'h0000;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_blank_off: assert property (st == 3'h1 |-> !switch_on_r) else $error("on in blank");
  a_blank_len: assert property ($rose(st == 3'h1) |-> (st == 3'h1)[*3] ##[1:3] st == 3'h2)
    else $error("blank length wrong");
  a_blank_min: assert property ($fell(st == 3'h1) && emu |->
    blank_run_r >= BLANK_CYC) else $error("blank too short");
  a_off_hold: assert property (emu[*8] ##0 st == 3'h2 |-> !switch_on_r)
    else $error("on in off state");
  a_on_state: assert property (emu[*8] ##0 st == 3'h4 |-> switch_on_r)
    else $error("off in on state");
  a_fwd_exit: assert property ((drain_forward && !drain_negative)[*8] |-> st != 3'h4)
    else $error("stuck on with forward current");
  a_ot_pwm: assert property (switch_overheat[*8] |-> temp_pwm_r) else $error("pwm not high");
  a_drv_off: assert property (driver_overheat[*8] |-> !switch_on_r && !rails_enable_r)
    else $error("driver overheat not off");
  a_fault_ot: assert property ((switch_overheat || driver_overheat)[*8] |-> !fault_b_r)
    else $error("fault released in overheat");
  a_rail_gate: assert property (!aux_five_volt_rail_ok[*8] |-> !fault_b_r)
    else $error("fault released without rail");
  cover property (st == 3'h4);
  cover property ($rose(st == 3'h1));
  cover property ($rose(fault_b_r));
endmodule

bind trd_top trd_chk #(.BLANK_CYC(BLANK_CYC)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .switch_overheat(switch_overheat),
  .driver_overheat(driver_overheat), .drain_negative(drain_negative),
  .drain_forward(drain_forward), .aux_five_volt_rail_ok(aux_five_volt_rail_ok),
  .switch_on_r(switch_on_r), .rails_enable_r(rails_enable_r), .fault_b_r(fault_b_r),
  .temp_pwm_r(temp_pwm_r), .diode_emulation_state_r(diode_emulation_state_r)
);

// file: tb/trd_ctrl_model.sv
`timescale 1ns/1ps
module trd_ctrl_model (
  input  wire sys_clk,
  input  wire fire,
  output reg  gate_cmd
);
  reg [3:0] cnt_r = 4'h0;
  initial gate_cmd = 1'b0;
  // One gate pulse per request, ending in a falling edge
  always @(posedge sys_clk)
  begin
    if (fire && cnt_r == 4'h0) cnt_r <= 4'hC;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    gate_cmd <= (cnt_r > 4'h1);
  end
endmodule

// file: tb/trd_top_test.sv
`timescale 1ns/1ps
module trd_top_test;
  reg sys_clk = 0, rst_b = 0, fire = 0, rise = 0, fall = 0, aux = 0, neg = 0;
  reg sot = 0, dot = 0, dneg = 0, dfwd = 0;
  reg [7:0] temp = 8'h00;
  wire gate, sw, rails, fb, pwm;
  wire [2:0] st;
  integer error_cnt = 0, checked = 0, hi, rs, e, i;
  int q[$] = '{0, 4, 5, 130, 150, 0};
  trd_ctrl_model ctl_u (.sys_clk(sys_clk), .fire(fire), .gate_cmd(gate));
  trd_top #(.BLANK_CYC(4), .PWM_PERIOD(2000)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .gate_cmd(gate), .supply_above_rise(rise), .supply_above_fall(fall),
    .aux_five_volt_rail_ok(aux), .negative_bias_rail_ok(neg), .switch_overheat(sot),
    .driver_overheat(dot), .drain_negative(dneg), .drain_forward(dfwd), .temp_code(temp),
    .switch_on_r(sw), .rails_enable_r(rails), .fault_b_r(fb), .temp_pwm_r(pwm),
    .diode_emulation_state_r(st));
  initial forever #2.5 sys_clk = ~sys_clk;
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task report_and_stop;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #250000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    void'($urandom(71));
    q[5] = $urandom % 150;
    cyc(16);
    check(8'({st, sw, rails, pwm}), 8'h10, "reset outputs");
    check(8'(fb), 0, "fault_b");
    @(posedge sys_clk) rst_b <= 1;
    @(posedge sys_clk) {rise, fall} <= 2'h3;
    cyc(12);
    check(8'(rails), 1, "rails");
    check(8'(fb), 0, "fault_b");
    @(posedge sys_clk) {rise, fall} <= 2'h0;
    cyc(12);
    check(8'(rails), 0, "rails");
    @(posedge sys_clk) {rise, fall, aux, neg} <= 4'hF;
    cyc(14);
    check(8'(fb), 1, "fault_b");
    @(posedge sys_clk) fire <= 1;
    @(posedge sys_clk) fire <= 0;
    cyc(10);
    check(8'(sw), 1, "switch");
    foreach (q[k])
    begin
      @(posedge sys_clk) temp <= q[k];
      cyc(4000);
      hi = 0;
      rs = 0;
      for (i = 0; i < 2000; i++)
      begin
        e = pwm;
        cyc(1);
        rs += (pwm && !e);
        hi += pwm;
      end
      e = (q[k] < 5) ? 20 : $rtoi(2000.0 * (q[k] + 20 - 20.1) / 162.3);
      check(8'(hi >= e - 4 && hi <= e + 4), 1, "duty");
      check(8'(rs), 1, "periods");
    end
    @(posedge sys_clk) sot <= 1;
    cyc(10);
    check(8'(st), 2, "state");
    check(8'(fb), 0, "fault_b");
    check(8'(pwm), 1, "pwm");
    @(posedge sys_clk) dneg <= 1;
    cyc(8);
    check(8'(st), 4, "state");
    @(posedge sys_clk) {dneg, dfwd} <= 2'h1;
    cyc(8);
    check(8'({st, sw}), 8'h04, "state");
    @(posedge sys_clk) {fire, dfwd} <= 2'h2;
    @(posedge sys_clk) fire <= 0;
    for (i = 0; i < 40 && st !== 3'h1; i++) cyc(1);
    check(8'({st, sw}), 8'h02, "blank");
    cyc(3);
    check(8'(st), 1, "blank length");
    cyc(1);
    check(8'(st), 2, "state");
    @(posedge sys_clk) {dot, dneg} <= 2'h3;
    cyc(10);
    check(8'({sw, rails}), 0, "drv overheat");
    @(posedge sys_clk) dot <= 0;
    cyc(10);
    check(8'(st), 4, "state");
    @(posedge sys_clk) {sot, dneg} <= 2'h0;
    cyc(20);
    check(8'(fb), 1, "fault_b");
    report_and_stop;
  end
endmodule
